//--- src/fls_regs.svh
// register map, command codes and timing counts of the lock-bit host
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH

// ****************************************
// software register map
// ****************************************
`define FLS_OFS_CMD 8'h00
`define FLS_OFS_CTRL 8'h04
`define FLS_OFS_STAT 8'h08

// cmd register fields
`define FLS_CMD_OP_LSB 0
`define FLS_CMD_OP_MSB 1
`define FLS_CMD_CODE_LSB 8
`define FLS_CMD_CODE_MSB 15

// ctrl register fields and reset value
`define FLS_CTRL_WP_BIT 0
`define FLS_CTRL_RP_BIT 1
`define FLS_CTRL_ACLR_BIT 2
`define FLS_CTRL_RESET 3'h6

// stat register fields; done (1) and refused (4) are write-one-to-clear
`define FLS_ST_BUSY 0
`define FLS_ST_DONE 1
`define FLS_ST_ERR 2
`define FLS_ST_UNKNOWN 3
`define FLS_ST_REFUSED 4
`define FLS_ST_MODE_LSB 5
`define FLS_ST_PIN 7
`define FLS_ST_SR_LSB 8

// ****************************************
// device status byte bits
// ****************************************
`define FLS_SR_READY 7
`define FLS_SR_ERASE_ERR 5
`define FLS_SR_PROG_ERR 4
`define FLS_SR_SUPPLY_LOW 3
`define FLS_SR_PROTECT 1

// ****************************************
// device command codes
// ****************************************
`define FLS_C_CLRLOCK_SETUP 8'h60
`define FLS_C_CONFIRM 8'hd0
`define FLS_C_STSCFG 8'hb8
`define FLS_C_CLRSTATUS 8'h50
`define FLS_C_RDSTATUS 8'h70

// ****************************************
// timing, in ns and in mclk cycles
// ****************************************
`define FLS_CLK_NS 4
`define FLS_T_SETUP_NS 10
`define FLS_T_WP_NS 50
`define FLS_T_HOLD_NS 10
`define FLS_T_ACC_NS 100
`define FLS_SETUP_CYC ((`FLS_T_SETUP_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_WP_CYC ((`FLS_T_WP_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
`define FLS_HOLD_CYC ((`FLS_T_HOLD_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS)
// two extra cycles cover the data synchroniser
`define FLS_ACC_CYC (((`FLS_T_ACC_NS + `FLS_CLK_NS - 1) / `FLS_CLK_NS) + 2)
`define FLS_POLL_CYC 64

`endif

//--- src/fls_pkg.sv
// types shared by the lock-bit host and its pin cycle engine
package fls_pkg;

    // ****************************************
    // flash pin bundle driven by the host
    // ****************************************
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic dq_oe_n;
        logic [7:0] dq_out;
    } fls_pins_t;

    // one bus cycle request
    typedef struct packed {
        logic is_write;
        logic [7:0] data;
    } fls_cyc_t;

    typedef enum logic [1:0] {
        FLS_OP_CLRLOCK = 2'b00,
        FLS_OP_STSCFG = 2'b01,
        FLS_OP_CLRSTAT = 2'b10,
        FLS_OP_RDSTAT = 2'b11
    } fls_op_t;

    typedef enum logic [2:0] {
        FLS_S_IDLE = 3'b000,
        FLS_S_CMD1 = 3'b001,
        FLS_S_CMD2 = 3'b010,
        FLS_S_WAIT = 3'b011,
        FLS_S_POLL = 3'b100,
        FLS_S_CLR = 3'b101
    } fls_state_t;

    typedef enum logic [1:0] {
        FLS_B_IDLE = 2'b00,
        FLS_B_SETUP = 2'b01,
        FLS_B_STROBE = 2'b10,
        FLS_B_HOLD = 2'b11
    } fls_bstate_t;

endpackage

//--- src/fls_bus_cycle.sv
// one timed write or read cycle on the flash pins
`timescale 1ns/100ps
`include "fls_regs.svh"

module fls_bus_cycle (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cyc_valid,
    input wire fls_pkg::fls_cyc_t cyc,
    output logic cyc_ready,
    output logic cyc_done,
    output logic [7:0] rdata_q,
    output fls_pkg::fls_pins_t pins_q,
    input wire logic [7:0] dq_in
);
    import fls_pkg::*;

    fls_bstate_t st_q;
    logic [7:0] cnt_q, dq_m_q, dq_s_q;
    logic wr_q;

    // ****************************************
    // cycle sequencer
    // ****************************************
    assign cyc_ready = (st_q == FLS_B_IDLE);
    assign cyc_done = (st_q == FLS_B_HOLD) && (cnt_q == 8'h01);

    // each phase loads its count and leaves when it reaches one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= FLS_B_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
        end else begin
            case (st_q)
                FLS_B_IDLE: begin
                    if (cyc_valid) begin
                        st_q <= FLS_B_SETUP;
                        wr_q <= cyc.is_write;
                        cnt_q <= 8'(`FLS_SETUP_CYC);
                    end
                end
                FLS_B_SETUP: begin
                    if (cnt_q == 8'h01) begin
                        st_q <= FLS_B_STROBE;
                        cnt_q <= wr_q ? 8'(`FLS_WP_CYC) : 8'(`FLS_ACC_CYC);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                FLS_B_STROBE: begin
                    if (cnt_q == 8'h01) begin
                        st_q <= FLS_B_HOLD;
                        cnt_q <= 8'(`FLS_HOLD_CYC);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                FLS_B_HOLD: begin
                    if (cnt_q == 8'h01) begin
                        st_q <= FLS_B_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= FLS_B_IDLE;
            endcase
        end
    end

    // pin drive; data stays on the bus through hold so the device latches it cleanly
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pins_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1, dq_out: 8'h00};
        end else if (st_q == FLS_B_IDLE) begin
            pins_q.ce_n <= ~cyc_valid;
            pins_q.we_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            pins_q.dq_oe_n <= ~(cyc_valid & cyc.is_write);
            pins_q.dq_out <= cyc.data;
        end else begin
            pins_q.we_n <= ~(wr_q && ((st_q == FLS_B_SETUP && cnt_q == 8'h01) ||
                                      (st_q == FLS_B_STROBE && cnt_q != 8'h01)));
            pins_q.oe_n <= ~(!wr_q && ((st_q == FLS_B_SETUP && cnt_q == 8'h01) ||
                                       (st_q == FLS_B_STROBE && cnt_q != 8'h01)));
            pins_q.ce_n <= cyc_done;
            pins_q.dq_oe_n <= ~wr_q | cyc_done;
        end
    end

    // data pins cross in through two flops before sampling
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dq_m_q <= 8'h00;
            dq_s_q <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            dq_m_q <= dq_in;
            dq_s_q <= dq_m_q;
            if (st_q == FLS_B_STROBE && cnt_q == 8'h01 && !wr_q) begin
                rdata_q <= dq_s_q;
            end
        end
    end

endmodule

//--- src/fls_host.sv
// host controller that clears flash lock-bits and configures the status pin
// Contract
// - clear is setup write then confirm write
// - completion via status pin or ready bit
// - host checks erase error, clears status
// - aborted clear leaves bits unknown; repeat
// - configure pin with command plus code
`timescale 1ns/100ps
`include "fls_regs.svh"

module fls_host (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    output fls_pkg::fls_pins_t flash_pins,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_event_pin,
    output logic reset_powerdown_n,
    output logic write_protect_n
);
    import fls_pkg::*;

    fls_state_t st_q;
    fls_op_t op_q;
    fls_cyc_t cyc;
    logic [7:0] code_q, sr_q, poll_q, rdata;
    logic [2:0] ctrl_q;
    logic [1:0] mode_q;
    logic issued_q, done_q, err_q, unknown_q, refused_q;
    logic pin_m_q, pin_s_q, pin_d_q, pulse_seen_q;
    logic cyc_valid, cyc_ready, cyc_done;
    logic busy, abort, bus_rst, cmd_wr, start, finish;
    logic sr_ready, sr_fail, pin_ready;

    // ****************************************
    // pin cycle engine
    // ****************************************
    assign busy = (st_q != FLS_S_IDLE);
    // pulling the reset pin mid-operation abandons the cycle in flight
    assign abort = busy && !ctrl_q[`FLS_CTRL_RP_BIT];
    assign bus_rst = sys_rst | abort;
    assign cyc_valid = (st_q != FLS_S_IDLE) && (st_q != FLS_S_WAIT) && !issued_q;

    // command byte for each state of the sequence
    always_comb begin
        cyc = '{is_write: 1'b1, data: 8'h00};
        case (st_q)
            FLS_S_CMD1: begin
                case (op_q)
                    FLS_OP_CLRLOCK: cyc.data = `FLS_C_CLRLOCK_SETUP;
                    FLS_OP_STSCFG: cyc.data = `FLS_C_STSCFG;
                    FLS_OP_CLRSTAT: cyc.data = `FLS_C_CLRSTATUS;
                    default: cyc.data = `FLS_C_RDSTATUS;
                endcase
            end
            // confirm code or pin configuration code, always the second write
            FLS_S_CMD2: cyc.data = (op_q == FLS_OP_CLRLOCK) ? `FLS_C_CONFIRM : code_q;
            // device already returns status after the clear, so no read-status command
            FLS_S_POLL: cyc.is_write = 1'b0;
            FLS_S_CLR: cyc.data = `FLS_C_CLRSTATUS;
            default: cyc.data = 8'h00;
        endcase
    end

    fls_bus_cycle u_cycle (
        .mclk(mclk),
        .sys_rst(bus_rst),
        .cyc_valid(cyc_valid),
        .cyc(cyc),
        .cyc_ready(cyc_ready),
        .cyc_done(cyc_done),
        .rdata_q(rdata),
        .pins_q(flash_pins),
        .dq_in(flash_dq_in)
    );

    // ****************************************
    // status pin tracking
    // ****************************************
    // pin is open drain: low means busy or a completion pulse
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_m_q <= 1'b1;
            pin_s_q <= 1'b1;
            pin_d_q <= 1'b1;
        end else begin
            pin_m_q <= ready_event_pin;
            pin_s_q <= pin_m_q;
            pin_d_q <= pin_s_q;
        end
    end

    // any low pulse counts, whatever its width, so the pulse length needs no match here
    always_ff @(posedge mclk) begin
        if (sys_rst || start) begin
            pulse_seen_q <= 1'b0;
        end else if (pin_d_q && !pin_s_q) begin
            pulse_seen_q <= 1'b1;
        end
    end

    // level mode: released pin means ready; pulsed modes: a seen pulse means done
    assign pin_ready = (mode_q == 2'b00) ? pin_s_q : pulse_seen_q;

    // ****************************************
    // operation sequencer
    // ****************************************
    assign cmd_wr = reg_wr && (reg_addr == `FLS_OFS_CMD);
    // config needs the reset pin high; a busy host takes no new order
    assign start = cmd_wr && !busy &&
                   !(reg_wdata[`FLS_CMD_OP_MSB:`FLS_CMD_OP_LSB] == FLS_OP_STSCFG &&
                     !ctrl_q[`FLS_CTRL_RP_BIT]);
    assign sr_ready = rdata[`FLS_SR_READY];
    assign sr_fail = rdata[`FLS_SR_ERASE_ERR] | rdata[`FLS_SR_PROG_ERR] |
                     rdata[`FLS_SR_SUPPLY_LOW] | rdata[`FLS_SR_PROTECT];
    assign finish = cyc_done && (((st_q == FLS_S_CMD1) && (op_q == FLS_OP_CLRSTAT)) ||
                                 ((st_q == FLS_S_CMD2) && (op_q == FLS_OP_STSCFG)) ||
                                 (st_q == FLS_S_CLR) ||
                                 ((st_q == FLS_S_POLL) && (op_q == FLS_OP_RDSTAT)) ||
                                 ((st_q == FLS_S_POLL) && sr_ready &&
                                  !(ctrl_q[`FLS_CTRL_ACLR_BIT] && rdata[`FLS_SR_ERASE_ERR])));

    always_ff @(posedge mclk) begin
        if (sys_rst || abort) begin
            st_q <= FLS_S_IDLE;
        end else begin
            case (st_q)
                FLS_S_IDLE: begin
                    if (start) begin
                        st_q <= FLS_S_CMD1;
                    end
                end
                FLS_S_CMD1: begin
                    if (cyc_done) begin
                        if (op_q == FLS_OP_CLRSTAT) begin
                            st_q <= FLS_S_IDLE;
                        end else if (op_q == FLS_OP_RDSTAT) begin
                            st_q <= FLS_S_POLL;
                        end else begin
                            st_q <= FLS_S_CMD2;
                        end
                    end
                end
                FLS_S_CMD2: begin
                    if (cyc_done) begin
                        st_q <= (op_q == FLS_OP_CLRLOCK) ? FLS_S_WAIT : FLS_S_IDLE;
                    end
                end
                // wait for the pin, but poll anyway in case a pulse was missed
                FLS_S_WAIT: begin
                    if (pin_ready || poll_q == 8'(`FLS_POLL_CYC)) begin
                        st_q <= FLS_S_POLL;
                    end
                end
                FLS_S_POLL: begin
                    if (cyc_done) begin
                        if (finish) begin
                            st_q <= FLS_S_IDLE;
                        end else if (sr_ready) begin
                            st_q <= FLS_S_CLR;
                        end else begin
                            st_q <= FLS_S_WAIT;
                        end
                    end
                end
                FLS_S_CLR: begin
                    if (cyc_done) begin
                        st_q <= FLS_S_IDLE;
                    end
                end
                default: st_q <= FLS_S_IDLE;
            endcase
        end
    end

    // order latch, cycle issue flag and poll timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            op_q <= FLS_OP_RDSTAT;
            code_q <= 8'h00;
            issued_q <= 1'b0;
            poll_q <= 8'h00;
        end else begin
            if (start) begin
                op_q <= fls_op_t'(reg_wdata[`FLS_CMD_OP_MSB:`FLS_CMD_OP_LSB]);
                code_q <= reg_wdata[`FLS_CMD_CODE_MSB:`FLS_CMD_CODE_LSB];
            end
            if (abort || cyc_done) begin
                issued_q <= 1'b0;
            end else if (cyc_valid && cyc_ready) begin
                issued_q <= 1'b1;
            end
            poll_q <= (st_q == FLS_S_WAIT) ? poll_q + 8'h01 : 8'h00;
        end
    end

    // pin mode mirror: the device forgets it when its reset pin goes low
    always_ff @(posedge mclk) begin
        if (sys_rst || !ctrl_q[`FLS_CTRL_RP_BIT]) begin
            mode_q <= 2'b00;
        end else if (cyc_done && st_q == FLS_S_CMD2 && op_q == FLS_OP_STSCFG) begin
            mode_q <= code_q[1:0];
        end
    end

    // ****************************************
    // software registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_q <= `FLS_CTRL_RESET;
        end else if (reg_wr && reg_addr == `FLS_OFS_CTRL) begin
            ctrl_q <= reg_wdata[2:0];
        end
    end

    // write-protect pin level decides the protection outcome in the device unless its supply is low
    assign write_protect_n = ctrl_q[`FLS_CTRL_WP_BIT];
    assign reset_powerdown_n = ctrl_q[`FLS_CTRL_RP_BIT];

    // sticky flags; hardware set wins over the software clear in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sr_q <= 8'h00;
            done_q <= 1'b0;
            err_q <= 1'b0;
            unknown_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (st_q == FLS_S_POLL && cyc_done) begin
                sr_q <= rdata;
            end
            done_q <= (done_q & ~(reg_wr && reg_addr == `FLS_OFS_STAT && reg_wdata[`FLS_ST_DONE])) | finish;
            refused_q <= (refused_q & ~(reg_wr && reg_addr == `FLS_OFS_STAT && reg_wdata[`FLS_ST_REFUSED])) |
                         (cmd_wr & ~start);
            if (start) begin
                err_q <= 1'b0;
            end else if (st_q == FLS_S_POLL && cyc_done && sr_ready) begin
                err_q <= sr_fail;
            end
            // an aborted clear leaves lock-bits unknown until a clear succeeds
            if (abort && op_q == FLS_OP_CLRLOCK) begin
                unknown_q <= 1'b1;
            end else if (st_q == FLS_S_POLL && cyc_done && sr_ready && op_q == FLS_OP_CLRLOCK) begin
                unknown_q <= unknown_q & rdata[`FLS_SR_ERASE_ERR];
            end
        end
    end

    // read data one cycle after the strobe, zero for unmapped offsets
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `FLS_OFS_CTRL: reg_rdata_q <= 32'(ctrl_q);
                `FLS_OFS_STAT: reg_rdata_q <= {16'h0000, sr_q, pin_s_q, mode_q, refused_q,
                                               unknown_q, err_q, done_q, busy};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

endmodule

//--- verif/fls_host_asserts.sv
// concurrent checks on the lock-bit host ports
`timescale 1ns/100ps

module fls_host_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire fls_pkg::fls_pins_t flash_pins,
    input wire logic [7:0] flash_dq_in,
    input wire logic ready_event_pin,
    input wire logic reset_powerdown_n,
    input wire logic write_protect_n
);
    import fls_pkg::*;
    logic [7:0] we_low_q, oe_low_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // strobe widths and pin checks
    // ****************************************
    // low-cycle counters, cheaper than long repetitions
    always_ff @(posedge mclk) begin
        we_low_q <= (sys_rst || flash_pins.we_n) ? 8'h00 : we_low_q + 8'h01;
        oe_low_q <= (sys_rst || flash_pins.oe_n) ? 8'h00 : oe_low_q + 8'h01;
    end
    reset_pins_a:
        assert property ($fell(sys_rst) |-> flash_pins.ce_n && flash_pins.we_n && flash_pins.oe_n
            && flash_pins.dq_oe_n && reset_powerdown_n && !write_protect_n)
        else $error("flash pins not idle after reset");
    rdata_zero_a:
        assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0000_0000)
        else $error("read data outside its cycle");
    we_inside_a:
        assert property (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
        else $error("write strobe outside select");
    drive_guard_a:
        assert property (!flash_pins.dq_oe_n |-> !flash_pins.ce_n && flash_pins.oe_n)
        else $error("data driven during read");
    we_width_a:
        assert property ($rose(flash_pins.we_n) |-> we_low_q == 8'h0d)
        else $error("write strobe width wrong");
    read_width_a:
        assert property ($rose(flash_pins.oe_n) |-> oe_low_q == 8'h1b)
        else $error("read strobe width wrong");
    setup_time_a:
        assert property ($fell(flash_pins.we_n) |-> !$past(flash_pins.ce_n, 3) && !flash_pins.dq_oe_n)
        else $error("write setup too short");
    hold_time_a:
        assert property ($rose(flash_pins.we_n) |-> !flash_pins.ce_n [*3] ##1 flash_pins.ce_n)
        else $error("write hold wrong");
    data_stable_a:
        assert property (!flash_pins.dq_oe_n && !$past(flash_pins.dq_oe_n) |-> $stable(flash_pins.dq_out))
        else $error("write data moved");
    pin_levels_a:
        assert property (!$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(reset_powerdown_n)
            && $stable(write_protect_n))
        else $error("control pin moved without write");
endmodule

bind fls_host fls_host_asserts i_chk (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .flash_pins(flash_pins), .flash_dq_in(flash_dq_in), .ready_event_pin(ready_event_pin),
    .reset_powerdown_n(reset_powerdown_n), .write_protect_n(write_protect_n));

//--- verif/fls_flash_model.sv
// behavioural flash: command decoder, status byte, lock-bits, status pin
`timescale 1ns/100ps

module fls_flash_model #(
    parameter int BUSY_CYC = 200,
    parameter int PULSE_CYC = 8
) (
    input wire logic mclk,
    input wire fls_pkg::fls_pins_t pins,
    input wire logic reset_powerdown_n,
    input wire logic write_protect_n,
    input wire logic supply_low,
    output logic [7:0] dq,
    output logic sts_low,
    output logic [3:0] lock_q
);
    import fls_pkg::*;
    logic [7:0] sr_q = 8'h80, err_q = 8'h00, last_q = 8'h00;
    logic [1:0] mode_q = 2'b00; // level mode at power-up
    logic setup_q = 1'b0, cfg_q = 1'b0, stat_q = 1'b0, we_q = 1'b1;
    int busy_q = 0, pulse_q = 0;
    initial lock_q = 4'hf;
    // ****************************************
    // device state
    // ****************************************
    // commands taken on the rising write strobe
    always @(posedge mclk) begin
        we_q <= pins.we_n;
        if (!pins.ce_n && !pins.oe_n) last_q <= dq;
        if (!reset_powerdown_n) begin
            // abort leaves lock-bits in a junk state, pin back to level
            if (busy_q != 0) lock_q <= 4'ha;
            busy_q <= 0;
            pulse_q <= 0;
            mode_q <= 2'b00;
            setup_q <= 1'b0;
            cfg_q <= 1'b0;
        end else begin
            if (busy_q != 0) busy_q <= busy_q - 1;
            if (pulse_q != 0) pulse_q <= pulse_q - 1;
            if (busy_q == 1) begin
                // ready bit; codes 1 and 3 pulse on a clear, 2 does not
                sr_q <= 8'h80 | err_q;
                if (err_q == 8'h00) lock_q <= 4'h0; // every set bit at once
                if (mode_q[0]) pulse_q <= PULSE_CYC;
            end
            if (pins.we_n && !we_q && !pins.ce_n) begin
                // only read-array leaves status output
                stat_q <= pins.dq_out != 8'hff;
                cfg_q <= pins.dq_out == 8'hb8 && !cfg_q && !setup_q;
                setup_q <= pins.dq_out == 8'h60 && !cfg_q && !setup_q;
                if (cfg_q) mode_q <= pins.dq_out[1:0];
                else if (setup_q && pins.dq_out != 8'hd0) sr_q <= sr_q | 8'h30;
                else if (setup_q) begin
                    // supply and protect checks decide the outcome
                    err_q <= supply_low ? 8'h28 : (write_protect_n ? 8'h00 : 8'h22);
                    sr_q <= 8'h00;
                    busy_q <= BUSY_CYC;
                end else if (pins.dq_out == 8'h50) sr_q <= 8'h80;
            end
        end
    end
    // level mode low while busy, pulse modes only for the pulse
    assign sts_low = (mode_q == 2'b00 && busy_q != 0) || pulse_q != 0;
    // released bus shows the inverse of the last byte
    assign dq = (!pins.ce_n && !pins.oe_n) ? (stat_q ? sr_q : 8'hff) : ~last_q;
endmodule

//--- verif/fls_host_bench.sv
// self-checking bench for the lock-bit host against the flash model
`timescale 1ns/100ps
`include "fls_regs.svh"

module fls_host_bench;
    import fls_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata_q, rd;
    fls_pins_t flash_pins;
    logic [7:0] flash_dq;
    logic sts_low, ready_event_pin, reset_powerdown_n, write_protect_n;
    logic supply_low = 1'b0;
    logic [3:0] lock_bits;
    int num_errors = 0, tests_run = 0, falls = 0;
    // ****************************************
    // clock, pins and instances
    // ****************************************
    initial forever #2 mclk = ~mclk;
    // open drain with pull-up
    assign ready_event_pin = sts_low ? 1'b0 : 1'b1;
    always @(negedge ready_event_pin) falls++;
    fls_host i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .flash_pins(flash_pins),
        .flash_dq_in(flash_dq), .ready_event_pin(ready_event_pin),
        .reset_powerdown_n(reset_powerdown_n), .write_protect_n(write_protect_n));
    fls_flash_model i_flash (.mclk(mclk), .pins(flash_pins), .reset_powerdown_n(reset_powerdown_n),
        .write_protect_n(write_protect_n), .supply_low(supply_low), .dq(flash_dq), .sts_low(sts_low),
        .lock_q(lock_bits));
    // ****************************************
    // bus tasks
    // ****************************************
    // an idle edge after each strobe keeps one assignment per time step
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic reg_read(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata_q;
        @(posedge mclk);
    endtask
    task automatic check_val(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // leaves the last status word in rd
    task automatic run_cmd(input logic [31:0] c);
        reg_write(`FLS_OFS_CMD, c);
        for (int n = 0; n < 600; n++) begin
            reg_read(`FLS_OFS_STAT);
            if (rd[0] === 1'b0) return;
        end
        check_val("busy timeout", 32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        reg_read(`FLS_OFS_CTRL);
        check_val("ctrl reset", 32'h0000_0006, rd);
        reg_read(`FLS_OFS_STAT);
        check_val("stat reset", 32'h0000_0080, rd);
        reg_write(8'h0c, 32'hffff_ffff);
        reg_read(8'h0c);
        check_val("unmapped", 32'h0000_0000, rd);
        // protect low, auto clear of status afterwards
        run_cmd(32'h0000_0000);
        check_val("clear protected", 32'h0000_a286, rd);
        check_val("locks kept", 32'h0000_000f, 32'(lock_bits));
        reg_write(`FLS_OFS_STAT, 32'h0000_0012);
        reg_write(`FLS_OFS_CTRL, 32'h0000_0003);
        supply_low <= 1'b1;
        run_cmd(32'h0000_0000);
        check_val("clear low supply", 32'h0000_a886, rd);
        check_val("locks kept", 32'h0000_000f, 32'(lock_bits));
        run_cmd(32'h0000_0002);
        supply_low <= 1'b0;
        reg_write(`FLS_OFS_STAT, 32'h0000_0012);
        // a second order while busy is refused
        reg_write(`FLS_OFS_CMD, 32'h0000_0000);
        run_cmd(32'h0000_0000);
        check_val("clear good", 32'h0000_8092, rd);
        check_val("locks cleared", 32'h0000_0000, 32'(lock_bits));
        for (int c = 0; c < 4; c++) begin
            reg_write(`FLS_OFS_STAT, 32'h0000_0012);
            run_cmd(32'h0000_0001 | 32'(c << 8));
            check_val("pin mode", 32'(c), 32'(rd[6:5]));
            falls = 0;
            run_cmd(32'h0000_0000);
            check_val("pin events", (c == 2) ? 32'h0000_0000 : 32'h0000_0001, falls);
            check_val("clear in mode", 32'h0000_8082 | 32'(c << 5), rd);
        end
        reg_write(`FLS_OFS_STAT, 32'h0000_0012);
        reg_write(`FLS_OFS_CTRL, 32'h0000_0001);
        reg_write(`FLS_OFS_CMD, 32'h0000_0101);
        reg_read(`FLS_OFS_STAT);
        check_val("config rp low", 32'h0000_8090, rd);
        // abort a clear with the reset pin, then repeat it
        reg_write(`FLS_OFS_CTRL, 32'h0000_0003);
        reg_write(`FLS_OFS_CMD, 32'h0000_0000);
        repeat (80) @(posedge mclk);
        reg_write(`FLS_OFS_CTRL, 32'h0000_0001);
        run_cmd(32'h0000_0003);
        check_val("bits unknown", 32'h0000_0001, 32'(rd[3]));
        reg_write(`FLS_OFS_CTRL, 32'h0000_0003);
        run_cmd(32'h0000_0000);
        check_val("bits known", 32'h0000_0000, 32'(rd[3]));
        check_val("locks cleared", 32'h0000_0000, 32'(lock_bits));
        complete_run();
    end
    // hang guard, well past the expected run
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule
